// File: src/tcbp_cfg.svh
`ifndef TCBP_CFG_SVH
`define TCBP_CFG_SVH

// ----------------------------------------------------------------------
// command block layout
// ----------------------------------------------------------------------
`define TCBP_OFS_CMD 32'h0000_0000
`define TCBP_OFS_LINK 32'h0000_0004
`define TCBP_OFS_TBD 32'h0000_0008
`define TCBP_OFS_COUNT 32'h0000_000c
`define TCBP_OFS_DATA_ORIG 32'h0000_0010
`define TCBP_OFS_DATA_EXT 32'h0000_0020
`define TCBP_WORDS 2'h3

// ----------------------------------------------------------------------
// command word fields
// ----------------------------------------------------------------------
`define TCBP_BIT_EL 31
`define TCBP_BIT_S 30
`define TCBP_BIT_I 29
`define TCBP_CID_HI 28
`define TCBP_CID_LO 24
`define TCBP_BIT_NC 20
`define TCBP_BIT_SF 19
`define TCBP_CMD_HI 18
`define TCBP_CMD_LO 16
`define TCBP_CMD_TX 3'h4

// ----------------------------------------------------------------------
// status word fields
// ----------------------------------------------------------------------
`define TCBP_BIT_C 15
`define TCBP_BIT_OK 13
`define TCBP_BIT_U 12

// ----------------------------------------------------------------------
// count dword fields
// ----------------------------------------------------------------------
`define TCBP_TBDN_HI 31
`define TCBP_TBDN_LO 24
`define TCBP_THR_HI 23
`define TCBP_THR_LO 16
`define TCBP_BIT_EOF 15
`define TCBP_BC_HI 13
`define TCBP_BC_LO 0
`define TCBP_NULL_PTR 32'hffff_ffff
`define TCBP_THR_SHIFT 3

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define TCBP_CLK_MHZ 200
`define TCBP_CID_TICK_NS 1000
`define TCBP_CID_TICK_CYC \
   ((`TCBP_CID_TICK_NS * `TCBP_CLK_MHZ + 999) / 1000)

`endif

// File: src/tcbp_pkg.sv
package tcbp_pkg;

   // ------------------------------------------------------------------
   // command unit states
   // ------------------------------------------------------------------
   typedef enum logic [6:0]
   {
      TCBP_ST_IDLE = 7'h01,
      TCBP_ST_FETCH = 7'h02,
      TCBP_ST_DECODE = 7'h04,
      TCBP_ST_XFER = 7'h08,
      TCBP_ST_STATUS = 7'h10,
      TCBP_ST_EVENTS = 7'h20,
      TCBP_ST_SUSP = 7'h40
   } tcbp_state_t;

   typedef logic [31:0] tcbp_dword_t;

endpackage

// File: src/tcbp_irq_delay.sv
`timescale 1ns/100ps
`include "tcbp_cfg.svh"

module tcbp_irq_delay (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // request
   input wire logic arm,
   input wire logic [4:0] delay_units,
   input wire logic raise_idle,
   input wire logic raise_inactive,
   // events
   output logic idle_event,
   output logic unit_inactive_event
);
   import tcbp_pkg::*;

   typedef struct packed {
      logic busy;
      logic [4:0] units;
      logic [15:0] tick;
      logic idle;
      logic inact;
      logic idle_out;
      logic inact_out;
   } tcbp_dly_t;

   tcbp_dly_t s_reg;
   tcbp_dly_t s_next;

   // ------------------------------------------------------------------
   // delay counter
   // ------------------------------------------------------------------
   always_comb
   begin
      s_next = s_reg;
      s_next.idle_out = 1'b0;
      s_next.inact_out = 1'b0;
      if (arm)
      begin
         // a new arm restarts the wait; the older event merges into it
         s_next.busy = 1'b1;
         s_next.units = delay_units;
         s_next.tick = 16'h0000;
         s_next.idle = raise_idle | (s_reg.busy & s_reg.idle);
         s_next.inact = raise_inactive | (s_reg.busy & s_reg.inact);
      end
      else if (s_reg.busy)
      begin
         if (s_reg.units == 5'h00)
         begin
            s_next.busy = 1'b0;
            s_next.idle_out = s_reg.idle;
            s_next.inact_out = s_reg.inact;
         end
         else if (s_reg.tick == 16'(`TCBP_CID_TICK_CYC - 1))
         begin
            s_next.tick = 16'h0000;
            s_next.units = s_reg.units - 5'h01;
         end
         else
         begin
            s_next.tick = s_reg.tick + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   assign idle_event = s_reg.idle_out;
   assign unit_inactive_event = s_reg.inact_out;

endmodule

// File: src/tcbp_tx_gate.sv
`timescale 1ns/100ps
`include "tcbp_cfg.svh"

module tcbp_tx_gate (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // threshold
   input wire logic arm,
   input wire logic [7:0] threshold,
   input wire logic [11:0] tx_fifo_level,
   // start
   output logic tx_go
);
   import tcbp_pkg::*;

   typedef struct packed {
      logic go;
   } tcbp_gate_t;

   tcbp_gate_t s_reg;
   tcbp_gate_t s_next;
   logic [11:0] need;

   // ------------------------------------------------------------------
   // start level
   // ------------------------------------------------------------------
   always_comb
   begin
      need = {1'b0, threshold, 3'h0};
      s_next = s_reg;
      // once started the frame keeps going until the gate is disarmed
      if (!arm)
         s_next.go = 1'b0;
      else if (tx_fifo_level >= need)
         s_next.go = 1'b1;
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   assign tx_go = s_reg.go;

endmodule

// File: src/tcbp_parser.sv
// Behaviour
// - simplified layout: frame bytes follow the command block in memory
// - flexible layout: data gathered through the descriptor array
// - configuration bit picks original or extended block format
// - command word holds flags, delay, zeros, no-insert, layout, code
// - dwords: command/status 00h, link 04h, descriptors 08h, counts next
// - next block address is link plus command unit base
// - end-of-list: go idle, always raise idle/inactive event
// - suspend: go suspended, inactive event only when configured
// - interrupt flag set raises command-done event, clear raises none
// - five-bit delay field postpones inactive events
// - no-insert clear: insert CRC and source address
// - no-insert clear with skip configured: insert CRC only
// - no-insert set: insert neither, send fields as fetched
// - layout-select bit decides simplified or flexible processing
// - layout 0 simplified with null array address, 1 flexible
// - completion bit set when DMA has handled the last byte
// - success bit set together with completion bit, but left clear for an unknown command code
// - threshold times 8 bytes must sit in FIFO before sending
`timescale 1ns/100ps
`include "tcbp_cfg.svh"

module tcbp_parser (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // command unit control
   input wire logic cu_start,
   input wire tcbp_pkg::tcbp_dword_t cu_start_ofs,
   input wire logic cu_resume,
   input wire tcbp_pkg::tcbp_dword_t cu_base,
   // configuration
   input wire logic cfg_extended_format,
   input wire logic skip_source_addr_insert,
   input wire logic cfg_inactive_irq_en,
   // host memory read
   output logic mem_rd_req,
   output tcbp_pkg::tcbp_dword_t mem_rd_addr,
   input wire logic mem_rd_ack,
   input wire tcbp_pkg::tcbp_dword_t mem_rd_data,
   // host memory write
   output logic mem_wr_req,
   output tcbp_pkg::tcbp_dword_t mem_wr_addr,
   output tcbp_pkg::tcbp_dword_t mem_wr_data,
   input wire logic mem_wr_ack,
   // transmit dma
   output logic dma_start,
   output logic dma_flexible,
   output tcbp_pkg::tcbp_dword_t dma_addr,
   output logic [13:0] dma_byte_count,
   output logic [7:0] dma_desc_count,
   output logic dma_eof,
   output logic insert_crc,
   output logic insert_src_addr,
   input wire logic dma_done,
   input wire logic tx_underrun,
   // transmit fifo
   input wire logic [11:0] tx_fifo_level,
   output logic tx_go,
   // events and state
   output logic command_done_event,
   output logic unit_inactive_event,
   output logic idle_event,
   output logic bad_command,
   output logic cu_idle,
   output logic cu_active,
   output logic cu_suspended
);
   import tcbp_pkg::*;

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   typedef struct packed {
      tcbp_state_t st;
      logic [1:0] idx;
      tcbp_dword_t transmit_command_block;
      tcbp_dword_t next;
      logic [3:0][31:0] w;
      logic ok;
      logic under;
      logic rd_req;
      tcbp_dword_t rd_addr;
      logic wr_req;
      tcbp_dword_t wr_data;
      logic start;
      logic flex;
      tcbp_dword_t daddr;
      logic [13:0] bcount;
      logic [7:0] dcount;
      logic eof;
      logic crc;
      logic src;
      logic [7:0] thr;
      logic done_ev;
      logic bad;
      logic arm;
      logic [4:0] delay;
      logic raise_idle;
      logic raise_inact;
   } tcbp_main_t;

   tcbp_main_t s_reg;
   tcbp_main_t s_next;
   tcbp_dword_t cmd;
   tcbp_dword_t cnt;

   function automatic tcbp_dword_t add_base(input tcbp_dword_t base,
                                            input tcbp_dword_t ofs);
      add_base = base + ofs;
   endfunction

   // ------------------------------------------------------------------
   // command unit sequencer
   // ------------------------------------------------------------------
   always_comb
   begin
      s_next = s_reg;
      cmd = s_reg.w[0];
      cnt = s_reg.w[3];
      s_next.start = 1'b0;
      s_next.done_ev = 1'b0;
      s_next.bad = 1'b0;
      s_next.arm = 1'b0;
      case (s_reg.st)
         TCBP_ST_IDLE:
         begin
            if (cu_start)
            begin
               s_next.transmit_command_block = add_base(cu_base, cu_start_ofs);
               s_next.idx = 2'h0;
               s_next.rd_req = 1'b1;
               s_next.rd_addr = add_base(cu_base, cu_start_ofs);
               s_next.st = TCBP_ST_FETCH;
            end
         end
         TCBP_ST_FETCH:
         begin
            // one dword per accepted read, lowest offset first
            if (mem_rd_ack)
            begin
               s_next.w[s_reg.idx] = mem_rd_data;
               s_next.idx = s_reg.idx + 2'h1;
               s_next.rd_addr = s_reg.rd_addr + 32'h0000_0004;
               if (s_reg.idx == `TCBP_WORDS)
               begin
                  s_next.rd_req = 1'b0;
                  s_next.st = TCBP_ST_DECODE;
               end
            end
         end
         TCBP_ST_DECODE:
         begin
            s_next.next = add_base(cu_base, s_reg.w[1]);
            s_next.flex = cmd[`TCBP_BIT_SF];
            if (cmd[`TCBP_BIT_SF])
            begin
               s_next.daddr = s_reg.w[2];
               s_next.dcount = cnt[`TCBP_TBDN_HI:`TCBP_TBDN_LO];
            end
            else
            begin
               // array address is ignored here: software leaves it null
               s_next.daddr = s_reg.transmit_command_block + (cfg_extended_format ?
                  `TCBP_OFS_DATA_EXT : `TCBP_OFS_DATA_ORIG);
               s_next.dcount = 8'h00;
            end
            s_next.bcount = cnt[`TCBP_BC_HI:`TCBP_BC_LO];
            s_next.eof = cnt[`TCBP_BIT_EOF];
            s_next.thr = cnt[`TCBP_THR_HI:`TCBP_THR_LO];
            s_next.crc = !cmd[`TCBP_BIT_NC];
            s_next.src = !cmd[`TCBP_BIT_NC]
                         && !skip_source_addr_insert;
            // the original format has no delay field
            s_next.delay = cfg_extended_format ?
               cmd[`TCBP_CID_HI:`TCBP_CID_LO] : 5'h00;
            s_next.under = 1'b0;
            if (cmd[`TCBP_CMD_HI:`TCBP_CMD_LO] == `TCBP_CMD_TX)
            begin
               s_next.start = 1'b1;
               s_next.st = TCBP_ST_XFER;
            end
            else
            begin
               s_next.bad = 1'b1;
               s_next.ok = 1'b0;
               s_next.wr_req = 1'b1;
               s_next.wr_data = {cmd[31:16], 16'h8000};
               s_next.st = TCBP_ST_STATUS;
            end
         end
         TCBP_ST_XFER:
         begin
            if (dma_done)
            begin
               s_next.ok = 1'b1;
               s_next.wr_req = 1'b1;
               s_next.wr_data = cmd;
               s_next.wr_data[15:0] = 16'h0000;
               s_next.wr_data[`TCBP_BIT_C] = 1'b1;
               s_next.wr_data[`TCBP_BIT_OK] = 1'b1;
               s_next.wr_data[`TCBP_BIT_U] = tx_underrun;
               s_next.under = tx_underrun;
               s_next.st = TCBP_ST_STATUS;
            end
         end
         TCBP_ST_STATUS:
         begin
            if (mem_wr_ack)
            begin
               s_next.wr_req = 1'b0;
               s_next.st = TCBP_ST_EVENTS;
            end
         end
         TCBP_ST_EVENTS:
         begin
            s_next.done_ev = cmd[`TCBP_BIT_I];
            if (cmd[`TCBP_BIT_EL])
            begin
               s_next.arm = 1'b1;
               s_next.raise_idle = 1'b1;
               s_next.raise_inact = 1'b1;
               s_next.st = TCBP_ST_IDLE;
            end
            else if (cmd[`TCBP_BIT_S])
            begin
               s_next.arm = cfg_inactive_irq_en;
               s_next.raise_idle = 1'b0;
               s_next.raise_inact = 1'b1;
               s_next.st = TCBP_ST_SUSP;
            end
            else
            begin
               s_next.transmit_command_block = s_reg.next;
               s_next.idx = 2'h0;
               s_next.rd_req = 1'b1;
               s_next.rd_addr = s_reg.next;
               s_next.st = TCBP_ST_FETCH;
            end
         end
         TCBP_ST_SUSP:
         begin
            // a fresh start wins over a resume of the old chain
            if (cu_start || cu_resume)
            begin
               s_next.transmit_command_block = cu_start ?
                  add_base(cu_base, cu_start_ofs) : s_reg.next;
               s_next.idx = 2'h0;
               s_next.rd_req = 1'b1;
               s_next.rd_addr = cu_start ?
                  add_base(cu_base, cu_start_ofs) : s_reg.next;
               s_next.st = TCBP_ST_FETCH;
            end
         end
         default:
         begin
            s_next.st = TCBP_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         s_reg <= '0;
         s_reg.st <= TCBP_ST_IDLE;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   tcbp_irq_delay u_delay (
      .clk_sys(clk_sys),
      .rst(rst),
      .arm(s_reg.arm),
      .delay_units(s_reg.delay),
      .raise_idle(s_reg.raise_idle),
      .raise_inactive(s_reg.raise_inact),
      .idle_event(idle_event),
      .unit_inactive_event(unit_inactive_event)
   );

   tcbp_tx_gate u_gate (
      .clk_sys(clk_sys),
      .rst(rst),
      .arm(s_reg.st == TCBP_ST_XFER),
      .threshold(s_reg.thr),
      .tx_fifo_level(tx_fifo_level),
      .tx_go(tx_go)
   );

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   assign mem_rd_req = s_reg.rd_req;
   assign mem_rd_addr = s_reg.rd_addr;
   assign mem_wr_req = s_reg.wr_req;
   assign mem_wr_addr = s_reg.transmit_command_block;
   assign mem_wr_data = s_reg.wr_data;
   assign dma_start = s_reg.start;
   assign dma_flexible = s_reg.flex;
   assign dma_addr = s_reg.daddr;
   assign dma_byte_count = s_reg.bcount;
   assign dma_desc_count = s_reg.dcount;
   assign dma_eof = s_reg.eof;
   assign insert_crc = s_reg.crc;
   assign insert_src_addr = s_reg.src;
   assign command_done_event = s_reg.done_ev;
   assign bad_command = s_reg.bad;
   assign cu_idle = (s_reg.st == TCBP_ST_IDLE);
   assign cu_suspended = (s_reg.st == TCBP_ST_SUSP);
   assign cu_active = !cu_idle && !cu_suspended;

endmodule

// File: test/tcbp_props.sv
`timescale 1ns/100ps
module tcbp_props (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // configuration
   input wire logic cfg_extended_format,
   input wire logic skip_source_addr_insert,
   input wire logic cfg_inactive_irq_en,
   // host memory
   input wire logic mem_rd_req,
   input wire tcbp_pkg::tcbp_dword_t mem_rd_addr,
   input wire logic mem_rd_ack,
   input wire logic mem_wr_req,
   input wire tcbp_pkg::tcbp_dword_t mem_wr_data,
   input wire logic mem_wr_ack,
   // transmit dma
   input wire logic dma_start,
   input wire logic dma_flexible,
   input wire tcbp_pkg::tcbp_dword_t dma_addr,
   input wire logic [7:0] dma_desc_count,
   input wire logic insert_crc,
   input wire logic insert_src_addr,
   input wire logic dma_done,
   input wire logic tx_go,
   // events and state
   input wire logic command_done_event,
   input wire logic unit_inactive_event,
   input wire logic idle_event,
   input wire logic bad_command,
   input wire logic cu_idle,
   input wire logic cu_active,
   input wire logic cu_suspended
);
   import tcbp_pkg::*;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   // -----------------------------------------------------------------
   // properties
   // -----------------------------------------------------------------
   property p_rd_hold;
      mem_rd_req && !mem_rd_ack |=> mem_rd_req && $stable(mem_rd_addr);
   endproperty
   a_rd_hold: assert property (p_rd_hold)
      else $error("read moved");
   // blocks sit on 16-byte boundaries in every scenario
   property p_rd_step;
      mem_rd_req && mem_rd_ack && mem_rd_addr[3:2] != 2'h3
         |=> mem_rd_req && mem_rd_addr == $past(mem_rd_addr) + 32'h4;
   endproperty
   a_rd_step: assert property (p_rd_step)
      else $error("read order");
   property p_decode;
      mem_rd_req && mem_rd_ack && mem_rd_addr[3:2] == 2'h3
         |=> !mem_rd_req ##1 (dma_start || bad_command);
   endproperty
   a_decode: assert property (p_decode)
      else $error("no start");
   property p_wr_after;
      dma_done && cu_active |=> mem_wr_req;
   endproperty
   a_wr_after: assert property (p_wr_after)
      else $error("no status write");
   property p_status;
      mem_wr_req && mem_wr_data[18:16] == 3'h4
         |-> mem_wr_data[15] && mem_wr_data[13] && !mem_wr_data[14];
   endproperty
   a_status: assert property (p_status)
      else $error("bad status");
   property p_insert;
      dma_start && insert_src_addr |-> insert_crc && !skip_source_addr_insert;
   endproperty
   a_insert: assert property (p_insert)
      else $error("bad insert");
   property p_simple;
      dma_start && !dma_flexible |-> dma_desc_count == 8'h00;
   endproperty
   a_simple: assert property (p_simple)
      else $error("count set");
   property p_hold;
      dma_start |=> ($stable(dma_addr) && $stable(dma_flexible))[*3];
   endproperty
   a_hold: assert property (p_hold)
      else $error("setup moved");
   property p_go;
      cu_idle && $past(cu_idle) |-> !tx_go;
   endproperty
   a_go: assert property (p_go)
      else $error("go in idle");
   // original format has no delay field, so the gap is fixed
   property p_idle_evt;
      $rose(cu_idle) && !cfg_extended_format
         |-> ##2 idle_event && unit_inactive_event;
   endproperty
   a_idle_evt: assert property (p_idle_evt)
      else $error("no idle events");
   property p_susp_evt;
      $rose(cu_suspended) && !cfg_extended_format
         |-> ##2 unit_inactive_event == cfg_inactive_irq_en && !idle_event;
   endproperty
   a_susp_evt: assert property (p_susp_evt)
      else $error("suspend event");
   property p_cx;
      logic irq;
      (mem_wr_req && mem_wr_ack, irq = mem_wr_data[29])
         |-> ##2 command_done_event == irq;
   endproperty
   a_cx: assert property (p_cx)
      else $error("done event");
   c_flex: cover property (dma_start && dma_flexible);
   c_susp: cover property ($rose(cu_suspended));
   c_go: cover property (tx_go && !insert_src_addr);
endmodule

bind tcbp_parser tcbp_props u_props (.*);

// File: test/tcbp_host_mem.sv
`timescale 1ns/100ps
module tcbp_host_mem (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // answer latency in cycles
   input wire logic [3:0] lat,
   // read
   input wire logic rd_req,
   input wire tcbp_pkg::tcbp_dword_t rd_addr,
   output logic rd_ack,
   output tcbp_pkg::tcbp_dword_t rd_data,
   // write
   input wire logic wr_req,
   input wire tcbp_pkg::tcbp_dword_t wr_addr,
   input wire tcbp_pkg::tcbp_dword_t wr_data,
   output logic wr_ack
);
   import tcbp_pkg::*;
   tcbp_dword_t mem [0:255];
   tcbp_dword_t last_wr_addr;
   tcbp_dword_t last_wr_data;
   int n_wr;
   logic [3:0] rd_wait;
   logic [3:0] wr_wait;

   // software side: one block per frame, reserved bits written zero
   task automatic load_tcb(input logic [9:0] a, input logic [2:0] esi,
      input logic [4:0] completion_irq_delay, input logic nc, input logic sf,
      input tcbp_dword_t link, input logic [7:0] tbdn,
      input logic [7:0] thr, input logic [13:0] bc);
      mem[a[9:2]] = {esi, completion_irq_delay, 3'h0, nc, sf, 3'h4, 16'h0000};
      mem[a[9:2] + 8'h1] = link;
      mem[a[9:2] + 8'h2] = sf ? 32'h0000_0300 : 32'hffff_ffff;
      mem[a[9:2] + 8'h3] = {tbdn, thr, 2'h2, bc};
   endtask

   always @(posedge clk_sys)
   begin
      rd_ack <= 1'b0;
      wr_ack <= 1'b0;
      // released bus shows the inverse
      rd_data <= ~rd_data;
      if (rst)
      begin
         rd_wait <= 4'h0;
         wr_wait <= 4'h0;
         rd_data <= 32'h0;
         n_wr <= 0;
      end
      else
      begin
         if (rd_req && !rd_ack)
         begin
            rd_wait <= rd_wait + 4'h1;
            if (rd_wait >= lat)
            begin
               rd_ack <= 1'b1;
               rd_data <= mem[rd_addr[9:2]];
               rd_wait <= 4'h0;
            end
         end
         if (wr_req && !wr_ack)
         begin
            wr_wait <= wr_wait + 4'h1;
            if (wr_wait >= lat)
            begin
               wr_ack <= 1'b1;
               last_wr_addr <= wr_addr;
               last_wr_data <= wr_data;
               n_wr <= n_wr + 1;
               wr_wait <= 4'h0;
            end
         end
      end
   end
endmodule

// File: test/tb.sv
`timescale 1ns/100ps
module tb;
   import tcbp_pkg::*;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic cu_start = 1'b0;
   logic cu_resume = 1'b0;
   tcbp_dword_t cu_start_ofs = 32'h0;
   tcbp_dword_t cu_base = 32'h0000_0100;
   logic cfg_extended_format = 1'b0;
   logic skip_source_addr_insert = 1'b0;
   logic cfg_inactive_irq_en = 1'b0;
   logic mem_rd_req, mem_rd_ack, mem_wr_req, mem_wr_ack;
   tcbp_dword_t mem_rd_addr, mem_rd_data, mem_wr_addr, mem_wr_data, dma_addr;
   logic dma_start, dma_flexible, dma_eof, insert_crc, insert_src_addr;
   logic [13:0] dma_byte_count;
   logic [7:0] dma_desc_count;
   logic dma_done = 1'b0;
   logic tx_underrun = 1'b0;
   logic [11:0] tx_fifo_level = 12'h000;
   logic tx_go, command_done_event, unit_inactive_event, idle_event;
   logic bad_command, cu_idle, cu_active, cu_suspended;
   logic [3:0] lat = 4'h0;
   int n_mismatch = 0;
   int samples_checked = 0;
   int n_cx = 0, n_idle = 0, n_ina = 0, cyc = 0, t_evt = 0;

   always #2.5 clk_sys = ~clk_sys;

   tcbp_parser uut (.*);
   tcbp_host_mem u_mem (.clk_sys, .rst, .lat, .rd_req(mem_rd_req),
      .rd_addr(mem_rd_addr), .rd_ack(mem_rd_ack), .rd_data(mem_rd_data),
      .wr_req(mem_wr_req), .wr_addr(mem_wr_addr), .wr_data(mem_wr_data),
      .wr_ack(mem_wr_ack));

   // pulses last one cycle
   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      if (command_done_event === 1'b1)
         n_cx <= n_cx + 1;
      if (unit_inactive_event === 1'b1)
         n_ina <= n_ina + 1;
      if (idle_event === 1'b1)
      begin
         n_idle <= n_idle + 1;
         t_evt <= cyc;
      end
   end

   task automatic chk(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic kick(input logic res, input tcbp_dword_t ofs);
      cu_start_ofs = ofs;
      cu_start = !res;
      cu_resume = res;
      @(negedge clk_sys);
      cu_start = 1'b0;
      cu_resume = 1'b0;
   endtask

   task automatic wait_start();
      int k;
      for (k = 0; k < 300 && dma_start !== 1'b1; k++)
         @(negedge clk_sys);
      chk("dma_start", 32'(dma_start), 32'h1);
   endtask

   task automatic finish_block(input logic und);
      int k;
      int w;
      w = u_mem.n_wr;
      tx_underrun = und;
      repeat (3) @(negedge clk_sys);
      dma_done = 1'b1;
      @(negedge clk_sys);
      dma_done = 1'b0;
      for (k = 0; k < 100 && u_mem.n_wr == w; k++)
         @(negedge clk_sys);
      tx_underrun = 1'b0;
      chk("status_writes", 32'(u_mem.n_wr - w), 32'h1);
   endtask

   // -----------------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------------
   task automatic sc_simple();
      int c0;
      int i0;
      c0 = n_cx;
      i0 = n_idle;
      cfg_extended_format = 1'b1;
      tx_fifo_level = 12'h008;
      u_mem.load_tcb(10'h140, 3'h5, 5'h0, 1'b0, 1'b0, 32'h0, 8'h0, 8'h1,
         14'h003c);
      kick(1'b0, 32'h40);
      wait_start();
      chk("flexible", 32'(dma_flexible), 32'h0);
      chk("inline_addr", dma_addr, 32'h160);
      chk("byte_count", 32'(dma_byte_count), 32'h3c);
      chk("eof", 32'(dma_eof), 32'h1);
      chk("crc_src", 32'({insert_crc, insert_src_addr}), 32'h3);
      finish_block(1'b0);
      chk("status_addr", u_mem.last_wr_addr, 32'h140);
      chk("status_word", u_mem.last_wr_data, 32'ha004_a000);
      repeat (8) @(negedge clk_sys);
      chk("done_events", 32'(n_cx - c0), 32'h1);
      chk("idle_events", 32'(n_idle - i0), 32'h1);
      chk("idle", 32'(cu_idle), 32'h1);
   endtask

   // slow memory, flexible block linked to a simplified one
   task automatic sc_chain();
      int c0;
      c0 = n_cx;
      lat = 4'h3;
      cfg_extended_format = 1'b0;
      u_mem.load_tcb(10'h180, 3'h0, 5'h0, 1'b1, 1'b1, 32'hc0, 8'h2, 8'h0,
         14'h0);
      u_mem.load_tcb(10'h1c0, 3'h5, 5'h0, 1'b1, 1'b0, 32'h0, 8'h0, 8'h0,
         14'h8);
      kick(1'b0, 32'h80);
      wait_start();
      chk("flexible", 32'(dma_flexible), 32'h1);
      chk("desc_array", dma_addr, 32'h300);
      chk("desc_count", 32'(dma_desc_count), 32'h2);
      chk("crc_src", 32'({insert_crc, insert_src_addr}), 32'h0);
      finish_block(1'b0);
      wait_start();
      chk("linked_inline", dma_addr, 32'h1d0);
      finish_block(1'b0);
      chk("status_addr", u_mem.last_wr_addr, 32'h1c0);
      repeat (8) @(negedge clk_sys);
      chk("done_events", 32'(n_cx - c0), 32'h1);
      lat = 4'h0;
   endtask

   task automatic sc_suspend();
      int i0;
      int n0;
      int k;
      skip_source_addr_insert = 1'b1;
      cfg_inactive_irq_en = 1'b1;
      tx_fifo_level = 12'h00f;
      u_mem.load_tcb(10'h200, 3'h2, 5'h0, 1'b0, 1'b0, 32'h140, 8'h0, 8'h2,
         14'h20);
      u_mem.load_tcb(10'h240, 3'h4, 5'h1, 1'b0, 1'b0, 32'h0, 8'h0, 8'h0,
         14'h20);
      kick(1'b0, 32'h100);
      wait_start();
      chk("crc_src", 32'({insert_crc, insert_src_addr}), 32'h2);
      repeat (4) @(negedge clk_sys);
      chk("go_below", 32'(tx_go), 32'h0);
      tx_fifo_level = 12'h010;
      repeat (3) @(negedge clk_sys);
      chk("go_at", 32'(tx_go), 32'h1);
      n0 = n_ina;
      i0 = n_idle;
      finish_block(1'b1);
      chk("status_word", u_mem.last_wr_data, 32'h4004_b000);
      repeat (8) @(negedge clk_sys);
      chk("suspended", 32'(cu_suspended), 32'h1);
      chk("inactive_events", 32'(n_ina - n0), 32'h1);
      chk("idle_events", 32'(n_idle - i0), 32'h0);
      cfg_extended_format = 1'b1;
      kick(1'b1, 32'h0);
      wait_start();
      chk("resumed_inline", dma_addr, 32'h260);
      finish_block(1'b0);
      for (k = 0; k < 50 && cu_idle !== 1'b1; k++)
         @(negedge clk_sys);
      n0 = cyc;
      i0 = n_idle;
      for (k = 0; k < 400 && n_idle == i0; k++)
         @(negedge clk_sys);
      chk("delay_ok", 32'(t_evt - n0 > 195 && t_evt - n0 < 215), 32'h1);
   endtask

   initial
   begin
      repeat (2) @(negedge clk_sys);
      rst = 1'b0;
      @(negedge clk_sys);
      sc_simple();
      sc_chain();
      sc_suspend();
      give_verdict();
   end

   initial
   begin
      repeat (3000) @(posedge clk_sys);
      n_mismatch++;
      give_verdict();
   end
endmodule
